// ==== hdl/acq_mode_config.v ====
// Acquisition-mode configuration of a time-of-flight sensor: register file, mode decode,
// and the capture sequencer that walks correlation samples frame by frame.
// Assumes a single core_clk domain and a master that never issues read and write together.
`timescale 1ns/1ps
`include "acq_mode_defines.vh"

module acq_mode_config #(
    parameter ADDR_W = `ADDR_W,
    parameter DATA_W = `DATA_W
) (
    input  wire              core_clk,
    input  wire              resetn,
    input  wire [ADDR_W-1:0] reg_addr,
    input  wire [DATA_W-1:0] reg_wdata,
    input  wire              reg_wr,
    input  wire              reg_rd,
    output reg  [DATA_W-1:0] reg_rdata_q,
    input  wire              frame_start,
    input  wire              capture_done,
    output wire              capture_req_q,
    output wire [1:0]        sample_idx_q,
    output wire              integ_second_q,
    output wire              acq_busy_q,
    output wire              frame_done_q,
    output reg  [15:0]       integ2_length_q,
    output reg               modulation_on_q,
    output reg               grayscale_q,
    output reg               dual_mode_q,
    output reg               dual_int_active_q,
    output reg  [1:0]        column_step_q,
    output reg  [3:0]        row_step_q,
    output reg               bin_x_q,
    output reg               bin_y_q
);
    reg  [7:0] acq_mode_q;
    reg  [7:0] res_bin_q;
    reg  [7:0] integ2_high_q;
    reg  [7:0] integ2_low_q;
    reg        upper_pair_q;

    reg  [7:0] rd_mux;
    reg        dual_int_d;
    reg        modulation_on_d;
    reg        grayscale_d;
    reg  [1:0] column_step_d;
    reg  [3:0] row_step_d;
    reg  [15:0] integ2_length_d;
    reg        dual_mode_d;
    reg        bin_x_d;
    reg        bin_y_d;

    wire       wr_acq_mode = reg_wr && (reg_addr == `OFF_ACQ_MODE_SELECT);
    wire       wr_res_bin  = reg_wr && (reg_addr == `OFF_RES_BIN_FIELD);
    wire       wr_integ2_h = reg_wr && (reg_addr == `OFF_INTEG2_HIGH);
    wire       wr_integ2_l = reg_wr && (reg_addr == `OFF_INTEG2_LOW);

    wire [1:0] readout_code = acq_mode_q[`READOUT_MSB:`READOUT_LSB];
    wire [1:0] modsel_code  = acq_mode_q[`MODSEL_MSB:`MODSEL_LSB];
    wire [1:0] colred_code  = res_bin_q[`COLRED_MSB:`COLRED_LSB];
    wire [1:0] rowred_code  = res_bin_q[`ROWRED_MSB:`ROWRED_LSB];

    // Status: bit0 busy, bits2:1 sample index, bit3 second integration, bit4 upper pair
    wire [7:0] status_word  = {3'b000, upper_pair_q, integ_second_q, sample_idx_q, acq_busy_q};
    // Pair flips only after a dual-phase frame; other modes leave the choice alone
    wire       pair_flip    = frame_done_q && (readout_code == `READOUT_DUAL_PHASE);

    // Mode select; reserved bits are not stored and read back as zero
    always @(posedge core_clk) begin
        if (!resetn) begin
            acq_mode_q <= `RST_ACQ_MODE_SELECT;
        end else if (wr_acq_mode) begin
            acq_mode_q <= reg_wdata & `ACQ_MODE_MASK;
        end
    end

    // Resolution, binning and pixel-field mode; bit 6 is not stored
    always @(posedge core_clk) begin
        if (!resetn) begin
            res_bin_q <= `RST_RES_BIN_FIELD;
        end else if (wr_res_bin) begin
            res_bin_q <= reg_wdata & `RES_BIN_MASK;
        end
    end

    // Second integration length; halves written apart, so software updates it between frames
    always @(posedge core_clk) begin
        if (!resetn) begin
            integ2_high_q <= `RST_INTEG2_HIGH;
            integ2_low_q  <= `RST_INTEG2_LOW;
        end else begin
            if (wr_integ2_h) begin
                integ2_high_q <= reg_wdata;
            end
            if (wr_integ2_l) begin
                integ2_low_q <= reg_wdata;
            end
        end
    end

    // Read mux; unmapped addresses answer zero
    always @* begin
        case (reg_addr)
            `OFF_ACQ_MODE_SELECT: rd_mux = acq_mode_q;
            `OFF_RES_BIN_FIELD:   rd_mux = res_bin_q;
            `OFF_INTEG2_HIGH:     rd_mux = integ2_high_q;
            `OFF_INTEG2_LOW:      rd_mux = integ2_low_q;
            `OFF_ACQ_STATUS:      rd_mux = status_word;
            default:              rd_mux = 8'h00;
        endcase
    end

    // Read data stand only in the cycle after the strobe
    always @(posedge core_clk) begin
        if (!resetn) begin
            reg_rdata_q <= 8'h00;
        end else if (reg_rd) begin
            reg_rdata_q <= rd_mux;
        end else begin
            reg_rdata_q <= 8'h00;
        end
    end

    // Mode decode
    always @* begin
        // Exact match: any reduction or binning bit keeps single integration
        dual_int_d = acq_mode_q[`DUAL_INT_BIT] && (res_bin_q == `DUAL_FIELD_VALUE);
        integ2_length_d = {integ2_high_q, integ2_low_q};
        case (modsel_code)
            `MODSEL_TOF: begin
                modulation_on_d = 1'b1;
                grayscale_d     = 1'b0;
            end
            `MODSEL_GRAY: begin
                modulation_on_d = 1'b0;
                grayscale_d     = 1'b1;
            end
            default: begin
                // Reserved codes: illumination held off as the safe state
                modulation_on_d = 1'b0;
                grayscale_d     = 1'b1;
            end
        endcase
    end

    // Resolution, binning and pixel-field decode
    always @* begin
        dual_mode_d = res_bin_q[`FIELD_MODE_BIT];
        case (colred_code)
            `COLRED_NONE: column_step_d = 2'd1;
            `COLRED_HALF: column_step_d = 2'd2;
            default:      column_step_d = 2'd1;
        endcase
        case (rowred_code)
            `ROWRED_NONE:    row_step_d = 4'd1;
            `ROWRED_HALF:    row_step_d = 4'd2;
            `ROWRED_QUARTER: row_step_d = 4'd4;
            `ROWRED_EIGHTH:  row_step_d = 4'd8;
            default:         row_step_d = 4'd1;
        endcase
        // Binning needs a matching reduction and is barred in the dual modes
        bin_x_d = res_bin_q[`BIN_X_BIT] && (colred_code != `COLRED_NONE) && !dual_mode_d;
        bin_y_d = res_bin_q[`BIN_Y_BIT] && (rowred_code != `ROWRED_NONE) && !dual_mode_d;
    end

    // Registered configuration outputs
    always @(posedge core_clk) begin
        if (!resetn) begin
            integ2_length_q   <= 16'h0000;
            modulation_on_q   <= 1'b0;
            grayscale_q       <= 1'b0;
            dual_mode_q       <= 1'b0;
            dual_int_active_q <= 1'b0;
            column_step_q     <= 2'd1;
            row_step_q        <= 4'd1;
            bin_x_q           <= 1'b0;
            bin_y_q           <= 1'b0;
        end else begin
            integ2_length_q   <= integ2_length_d;
            modulation_on_q   <= modulation_on_d;
            grayscale_q       <= grayscale_d;
            dual_mode_q       <= dual_mode_d;
            dual_int_active_q <= dual_int_d;
            column_step_q     <= column_step_d;
            row_step_q        <= row_step_d;
            bin_x_q           <= bin_x_d;
            bin_y_q           <= bin_y_d;
        end
    end

    // Dual phase alternates the sample pair from one frame to the next
    always @(posedge core_clk) begin
        if (!resetn) begin
            upper_pair_q <= 1'b0;
        end else if (pair_flip) begin
            upper_pair_q <= ~upper_pair_q;
        end
    end

    capture_sequencer u_capture_sequencer (
        .core_clk       (core_clk),
        .resetn         (resetn),
        .frame_start    (frame_start),
        .capture_done   (capture_done),
        .readout_code   (readout_code),
        .dual_int       (dual_int_d),
        .upper_pair     (upper_pair_q),
        .capture_req_q  (capture_req_q),
        .sample_idx_q   (sample_idx_q),
        .integ_second_q (integ_second_q),
        .busy_q         (acq_busy_q),
        .frame_done_q   (frame_done_q)
    );
endmodule // acq_mode_config

// ==== hdl/acq_mode_defines.vh ====
// Register offsets, field positions, reset values and codes of the acquisition-mode block.
// Included by the register file and the capture sequencer; definitions only.
`ifndef ACQ_MODE_DEFINES_VH
`define ACQ_MODE_DEFINES_VH

`define ADDR_W                 8
`define DATA_W                 8

`define OFF_ACQ_MODE_SELECT    8'h92
`define OFF_RES_BIN_FIELD      8'h94
`define OFF_INTEG2_HIGH        8'h9e
`define OFF_INTEG2_LOW         8'h9f
`define OFF_ACQ_STATUS         8'ha0

`define RST_ACQ_MODE_SELECT    8'h34
`define RST_RES_BIN_FIELD      8'h00
`define RST_INTEG2_HIGH        8'h00
`define RST_INTEG2_LOW         8'h00

// Acquisition mode select fields
`define DUAL_INT_BIT           2
`define READOUT_LSB            4
`define READOUT_MSB            5
`define MODSEL_LSB             6
`define MODSEL_MSB             7
`define ACQ_MODE_MASK          8'hf4

// Resolution, binning and pixel-field fields
`define COLRED_LSB             0
`define COLRED_MSB             1
`define ROWRED_LSB             2
`define ROWRED_MSB             3
`define BIN_X_BIT              4
`define BIN_Y_BIT              5
`define FIELD_MODE_BIT         7
`define RES_BIN_MASK           8'hbf
`define DUAL_FIELD_VALUE       8'h80

// Readout-count codes
`define READOUT_GRAY           2'b00
`define READOUT_DUAL_PHASE     2'b01
`define READOUT_RESERVED       2'b10
`define READOUT_FULL           2'b11

// Modulation-select codes
`define MODSEL_TOF             2'b00
`define MODSEL_GRAY            2'b11

// Column / row reduction codes
`define COLRED_NONE            2'b00
`define COLRED_HALF            2'b01
`define ROWRED_NONE            2'b00
`define ROWRED_HALF            2'b01
`define ROWRED_QUARTER         2'b10
`define ROWRED_EIGHTH          2'b11

`endif

// ==== hdl/capture_sequencer.v ====
// Capture sequencer: walks the correlation samples of one frame, once or twice each.
// Assumes frame_start and capture_done are one-cycle pulses synchronous to core_clk.
`timescale 1ns/1ps
`include "acq_mode_defines.vh"

module capture_sequencer (
    input  wire       core_clk,
    input  wire       resetn,
    input  wire       frame_start,
    input  wire       capture_done,
    input  wire [1:0] readout_code,
    input  wire       dual_int,
    input  wire       upper_pair,
    output reg        capture_req_q,
    output reg  [1:0] sample_idx_q,
    output reg        integ_second_q,
    output reg        busy_q,
    output reg        frame_done_q
);
    localparam [1:0] ST_IDLE  = 2'd0;
    localparam [1:0] ST_ISSUE = 2'd1;
    localparam [1:0] ST_WAIT  = 2'd2;

    reg  [1:0] state_q;
    reg  [1:0] last_idx_q;
    reg        dual_q;
    reg  [1:0] first_idx;
    reg  [1:0] last_idx;

    // Sample span of the frame from the readout-count code
    always @* begin
        first_idx = 2'd0;
        last_idx  = 2'd0;
        case (readout_code)
            `READOUT_GRAY: begin
                first_idx = 2'd0;
                last_idx  = 2'd0;
            end
            `READOUT_DUAL_PHASE: begin
                first_idx = upper_pair ? 2'd2 : 2'd0;
                last_idx  = upper_pair ? 2'd3 : 2'd1;
            end
            `READOUT_FULL: begin
                first_idx = 2'd0;
                last_idx  = 2'd3;
            end
            default: begin
                // Reserved code falls back to a single sample
                first_idx = 2'd0;
                last_idx  = 2'd0;
            end
        endcase
    end

    always @(posedge core_clk) begin
        if (!resetn) begin
            state_q        <= ST_IDLE;
            last_idx_q     <= 2'd0;
            dual_q         <= 1'b0;
            capture_req_q  <= 1'b0;
            sample_idx_q   <= 2'd0;
            integ_second_q <= 1'b0;
            busy_q         <= 1'b0;
            frame_done_q   <= 1'b0;
        end else begin
            capture_req_q <= 1'b0;
            frame_done_q  <= 1'b0;
            case (state_q)
                ST_IDLE: begin
                    // Mode latched here so writes mid-frame cannot tear a frame
                    if (frame_start) begin
                        sample_idx_q   <= first_idx;
                        last_idx_q     <= last_idx;
                        dual_q         <= dual_int;
                        integ_second_q <= 1'b0;
                        busy_q         <= 1'b1;
                        state_q        <= ST_ISSUE;
                    end
                end
                ST_ISSUE: begin
                    capture_req_q <= 1'b1;
                    state_q       <= ST_WAIT;
                end
                ST_WAIT: begin
                    if (capture_done) begin
                        if (dual_q && !integ_second_q) begin
                            integ_second_q <= 1'b1;
                            state_q        <= ST_ISSUE;
                        end else if (sample_idx_q != last_idx_q) begin
                            sample_idx_q   <= sample_idx_q + 2'd1;
                            integ_second_q <= 1'b0;
                            state_q        <= ST_ISSUE;
                        end else begin
                            integ_second_q <= 1'b0;
                            busy_q         <= 1'b0;
                            frame_done_q   <= 1'b1;
                            state_q        <= ST_IDLE;
                        end
                    end
                end
                default: begin
                    state_q <= ST_IDLE;
                    busy_q  <= 1'b0;
                end
            endcase
        end
    end
endmodule // capture_sequencer

// ==== dv/acq_mode_config_props.sv ====
// Assertions on the acquisition-mode block's ports: register effects, dual gating, capture timing.
// Assumes one core_clk domain with synchronous active-low reset; attached by bind from the bench top.
`timescale 1ns/1ps
module acq_mode_config_props (
    input wire logic       core_clk,
    input wire logic       resetn,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic       reg_wr,
    input wire logic       reg_rd,
    input wire logic [7:0] reg_rdata_q,
    input wire logic       frame_start,
    input wire logic       capture_done,
    input wire logic       capture_req_q,
    input wire logic [1:0] sample_idx_q,
    input wire logic       integ_second_q,
    input wire logic       acq_busy_q,
    input wire logic       frame_done_q,
    input wire logic       modulation_on_q,
    input wire logic       grayscale_q,
    input wire logic       dual_mode_q,
    input wire logic       dual_int_active_q,
    input wire logic [1:0] column_step_q
);
    // Write data two edges back: config outputs lag the register by a cycle
    logic [7:0] wd1_q;
    logic [7:0] wd2_q;

    always_ff @(posedge core_clk) begin
        wd1_q <= reg_wdata;
        wd2_q <= wd1_q;
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!resetn);

    sequence s_wr_mode;
        reg_wr && reg_addr == 8'h92;
    endsequence
    sequence s_wr_res;
        reg_wr && reg_addr == 8'h94;
    endsequence
    sequence s_first_capture;
        ##1 (acq_busy_q && !sample_idx_q[0] && !integ_second_q && !capture_req_q) ##1 capture_req_q;
    endsequence

    property p_unmapped_read;
        reg_rd && reg_addr == 8'ha1 |=> reg_rdata_q == 8'h00;
    endproperty
    a_unmapped_read: assert property (p_unmapped_read) else $error("unmapped read returned data");

    property p_mod_decode;
        s_wr_mode |-> ##2 modulation_on_q == (wd2_q[7:6] == 2'h0) && grayscale_q == !modulation_on_q;
    endproperty
    a_mod_decode: assert property (p_mod_decode) else $error("modulation decode wrong");

    property p_dual_gate;
        reg_wr && ((reg_addr == 8'h94 && (reg_wdata & 8'hbf) != 8'h80) || (reg_addr == 8'h92 && !reg_wdata[2]))
            |-> ##2 !dual_int_active_q;
    endproperty
    a_dual_gate: assert property (p_dual_gate) else $error("dual integration active when gated");

    property p_field_mode;
        s_wr_res |-> ##2 dual_mode_q == wd2_q[7];
    endproperty
    a_field_mode: assert property (p_field_mode) else $error("pixel field mode wrong");

    property p_col_step;
        s_wr_res |-> ##2 column_step_q == ((wd2_q[1:0] == 2'h1) ? 2'h2 : 2'h1);
    endproperty
    a_col_step: assert property (p_col_step) else $error("column step wrong");

    property p_second_int;
        $rose(integ_second_q) |-> $past(capture_done) ##1 capture_req_q;
    endproperty
    a_second_int: assert property (p_second_int) else $error("second integration out of step");

    property p_first_req;
        frame_start && !acq_busy_q |-> s_first_capture;
    endproperty
    a_first_req: assert property (p_first_req) else $error("first capture request late");

    property p_frame_done;
        frame_done_q |-> $past(capture_done) && !acq_busy_q;
    endproperty
    a_frame_done: assert property (p_frame_done) else $error("frame done without capture done");
endmodule // acq_mode_config_props

// ==== dv/testbench.sv ====
// Self-checking bench for the acquisition-mode block: registers, mode decode, capture sequencing.
// Assumes design and checker compiled first; the bench is both register master and pixel side.
`timescale 1ns/1ps
module testbench;
    logic        core_clk;
    logic        resetn;
    logic        reg_wr;
    logic        reg_rd;
    logic        frame_start;
    logic        capture_done;
    logic [7:0]  reg_addr;
    logic [7:0]  reg_wdata;
    logic [7:0]  reg_rdata_q;
    logic        capture_req_q;
    logic [1:0]  sample_idx_q;
    logic        integ_second_q;
    logic        acq_busy_q;
    logic        frame_done_q;
    logic [15:0] integ2_length_q;
    logic        modulation_on_q;
    logic        grayscale_q;
    logic        dual_mode_q;
    logic        dual_int_active_q;
    logic [1:0]  column_step_q;
    logic [3:0]  row_step_q;
    logic        bin_x_q;
    logic        bin_y_q;
    int          err_count;
    int          n_compared;
    int          cycles = 0;

    acq_mode_config dut_u (
        .core_clk, .resetn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata_q, .frame_start,
        .capture_done, .capture_req_q, .sample_idx_q, .integ_second_q, .acq_busy_q, .frame_done_q,
        .integ2_length_q, .modulation_on_q, .grayscale_q, .dual_mode_q, .dual_int_active_q,
        .column_step_q, .row_step_q, .bin_x_q, .bin_y_q
    );

    always #5 core_clk = ~core_clk;

    // Whole run is under two hundred cycles; ceiling leaves wide margin
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            err_count++;
            summarize;
        end
    end

    task automatic summarize;
        $display("compared %0d, mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask

    // Read data stands only in the cycle after the strobe, zero after
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge core_clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1;
        chk(16'(reg_rdata_q), 16'(exp));
        @(posedge core_clk);
        #1;
        chk(16'(reg_rdata_q), 16'h0000);
    endtask

    task automatic settle;
        repeat (2) @(posedge core_clk);
        #1;
    endtask

    // One frame: n captures, sample order from base, each sample twice when dual
    task automatic frame(input int n, input bit dual, input int base);
        int k;
        logic [2:0] e;
        @(posedge core_clk);
        frame_start <= 1'b1;
        @(posedge core_clk);
        frame_start <= 1'b0;
        for (int i = 0; i < n; i++) begin
            k = 0;
            do begin
                @(posedge core_clk);
                #1;
                k++;
            end while (capture_req_q !== 1'b1 && k < 8);
            e = dual ? {2'(base + i / 2), i[0]} : {2'(base + i), 1'b0};
            chk(16'(k), 16'h0001);
            chk({13'h0, sample_idx_q, integ_second_q}, 16'(e));
            @(posedge core_clk);
            capture_done <= 1'b1;
            @(posedge core_clk);
            capture_done <= 1'b0;
            #1;
            chk({14'h0, frame_done_q, acq_busy_q}, (i == n - 1) ? 16'h0002 : 16'h0001);
        end
    endtask

    task automatic t_reset;
        rd(8'h92, 8'h34);
        rd(8'h94, 8'h00);
        rd(8'h9e, 8'h00);
        chk({13'h0, modulation_on_q, column_step_q}, 16'h0005);
        chk(16'(dual_int_active_q), 16'h0000);
        $display("test reset done");
    endtask

    task automatic t_regs;
        wr(8'h94, 8'hff);
        rd(8'h94, 8'hbf);
        wr(8'h92, 8'hff);
        rd(8'h92, 8'hf4);
        wr(8'ha1, 8'h5a);
        rd(8'ha1, 8'h00);
        wr(8'h9e, 8'h12);
        wr(8'h9f, 8'h34);
        settle;
        chk(integ2_length_q, 16'h1234);
        $display("test registers done");
    endtask

    task automatic t_modsel;
        for (int c = 0; c < 4; c += 3) begin
            wr(8'h92, {2'(c), 6'h00});
            settle;
            chk({14'h0, modulation_on_q, grayscale_q}, (c == 0) ? 16'h0002 : 16'h0001);
        end
        $display("test modulation done");
    endtask

    task automatic t_resol;
        for (int c = 0; c < 2; c++) begin
            wr(8'h94, {c[0], 6'h00, c[0]});
            settle;
            chk(16'(column_step_q), c ? 16'h0002 : 16'h0001);
            chk(16'(dual_mode_q), 16'(c));
        end
        wr(8'h94, 8'h15);
        settle;
        chk({10'h0, row_step_q, bin_x_q, bin_y_q}, 16'h000a);
        wr(8'h94, 8'h3d);
        settle;
        chk({10'h0, row_step_q, bin_x_q, bin_y_q}, 16'h0023);
        wr(8'h94, 8'hbd);
        settle;
        chk({10'h0, row_step_q, bin_x_q, bin_y_q}, 16'h0020);
        $display("test resolution done");
    endtask

    task automatic t_frames;
        wr(8'h94, 8'h00);
        wr(8'h92, 8'h00);
        frame(1, 0, 0);
        wr(8'h92, 8'h30);
        frame(4, 0, 0);
        wr(8'h92, 8'h10);
        frame(2, 0, 0);
        frame(2, 0, 2);
        $display("test readout counts done");
    endtask

    task automatic t_dual;
        wr(8'h94, 8'h80);
        wr(8'h92, 8'h34);
        settle;
        chk(16'(dual_int_active_q), 16'h0001);
        frame(8, 1, 0);
        wr(8'h94, 8'h81);
        settle;
        chk(16'(dual_int_active_q), 16'h0000);
        frame(4, 0, 0);
        rd(8'ha0, 8'h06);
        $display("test dual integration done");
    endtask

    initial begin
        core_clk = 1'b0;
        resetn = 1'b0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        frame_start = 1'b0;
        capture_done = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        err_count = 0;
        n_compared = 0;
        repeat (12) @(posedge core_clk);
        resetn <= 1'b1;
        t_reset;
        t_regs;
        t_modsel;
        t_resol;
        t_frames;
        t_dual;
        summarize;
    end
endmodule // testbench

bind acq_mode_config acq_mode_config_props props_u (
    .core_clk, .resetn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata_q, .frame_start, .capture_done,
    .capture_req_q, .sample_idx_q, .integ_second_q, .acq_busy_q, .frame_done_q, .modulation_on_q,
    .grayscale_q, .dual_mode_q, .dual_int_active_q, .column_step_q
);
